// File: cfb_defines.svh
// Offsets, field positions, reset values and fixed codes of the core flags block
`ifndef CFB_DEFINES_SVH
`define CFB_DEFINES_SVH
`define CFB_N_BIT        31
`define CFB_Z_BIT        30
`define CFB_C_BIT        29
`define CFB_V_BIT        28
`define CFB_Q_BIT        27
`define CFB_GE_HI        19
`define CFB_GE_LO        16
`define CFB_FLAGS_RESET  32'h00000000
`define CFB_FLOOR_RESET  8'h00
`define CFB_SP_RESET     32'h00000400
`define CFB_RET_MSP      32'hfffffff9
`define CFB_RET_PSP      32'hfffffffd
`define CFB_FRAME_WORDS  4'h8
`define CFB_FRAME_BYTES  32'h00000020
`define CFB_PC_SLOT_OFS  32'h00000018
`define CFB_PSR_SLOT_OFS 32'h0000001c
`define CFB_VEC_BASE     32'h00000000
`define CFB_IRQ_VEC_NUM  6'h10
`define CFB_SEL_APPLICATION_STATUS_FLAGS     2'h0
`define CFB_SEL_PSR      2'h1
`define CFB_SEL_FLOOR    2'h2
`define CFB_SEL_RAISE    2'h3
`define CFB_SIZE_BYTE    2'h0
`define CFB_SIZE_HALF    2'h1
`define CFB_MEM_WORDS    32
`endif

// File: cfb_pkg.sv
// Types shared by the core flags block and its users
package cfb_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_STACK, ST_UNSTACK} cfb_state_t;

	typedef struct packed {
		logic        valid;
		logic        sub;
		logic [31:0] a;
		logic [31:0] b;
	} cfb_alu_t;

	typedef struct packed {
		logic        valid;
		logic        signed_op;
		logic        hit;
	} cfb_sat_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  ge;
	} cfb_ge_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        priv;
		logic [1:0]  sel;
		logic [31:0] data;
	} cfb_sreg_t;

	typedef struct packed {
		logic        valid;
		logic        alias_acc;
		logic        write;
		logic [1:0]  size;
		logic [11:0] addr;
		logic [31:0] wdata;
	} cfb_mem_t;

	typedef struct packed {
		logic [31:0] r0;
		logic [31:0] r1;
		logic [31:0] r2;
		logic [31:0] r3;
		logic [31:0] r12;
		logic [31:0] lr;
		logic [31:0] ret_pc;
	} cfb_ctx_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic [31:0] value;
	} cfb_ret_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
	} cfb_bus_t;

	typedef struct packed {
		logic [31:0] application_status_flags;
		logic [7:0]  floor;
		logic [31:0] sp;
		logic [31:0] pc;
		logic [31:0] lr;
		logic        handler;
		logic [5:0]  exc_num;
	} cfb_status_t;

	typedef struct packed {
		cfb_state_t  fsm;
		logic        fn;
		logic        fz;
		logic        fc;
		logic        fv;
		logic        fq;
		logic [3:0]  ge;
		logic [7:0]  floor;
		logic [31:0] sp;
		logic [31:0] pc;
		logic [31:0] lr;
		logic        handler;
		logic [5:0]  exc_num;
		logic [2:0]  tgt;
		logic [3:0]  cnt;
		logic        vec_wait;
		logic        vec_done;
		logic        refetch;
		logic [31:0] vec_pc;
		logic [7:0]  active;
		logic [7:0]  irq_ack;
		cfb_bus_t    wr;
		cfb_bus_t    rd;
		logic [31:0] sreg_rdata;
		logic        sreg_rvalid;
		logic [31:0] mem_rdata;
		logic        mem_rvalid;
	} cfb_st_t;
endpackage

// File: cfb_core_flags.sv
// Status flags, bit-band alias memory, exception entry and return
`timescale 1ns/1ps
`include "cfb_defines.svh"

// What this block does
// - Negative flag at bit 31 follows the sign of the result.
// - Zero flag at bit 30 is one exactly when the result is zero.
// - Carry flag at bit 29: add carry, or subtract without borrow.
// - Overflow flag at bit 28 follows signed overflow of the operation.
// - Sticky saturation flag at bit 27 set by any saturating saturate op.
// - Saturation flag clears only by software move writing zero or by unstacking a saved status word with bit 27 clear.
// - Four greater-equal flags at bits 19 to 16, set by the greater-equal update.
// - Alias word write copies bit 0 into the targeted bit.
// - Alias write bits 31 to 1 are ignored.
// - Alias read returns 0 or 1 per targeted bit.
// - Words stored little-endian, low byte at lowest address.
// - After stacking, stack pointer holds lowest frame address.
// - Frame holds return address, reloaded into pc on return.
// - Vector fetch runs alongside stacking; handler starts when both finish.
// - Link register gets return code naming stack and prior mode.
// - Without late arrival, taken interrupt moves pending to active.
// - Late higher-priority arrival takes over; earlier stays pending.
// - In handler mode, return code loaded into pc returns.
// - Unprivileged moves reach only the application flags.
// - Unprivileged status writes ignore unallocated and execution bits.
// - Conditional raise writes only nonzero values, and only below a nonzero mask or into a zero mask.
// - No-operation op changes no state or flags.
module cfb_core_flags (
	input  wire logic               clock,        // Core clock
	input  wire logic               rst,          // Async reset, active high
	input  wire cfb_pkg::cfb_alu_t  alu,          // Add or subtract flag update
	input  wire cfb_pkg::cfb_sat_t  sat,          // Saturate op outcome
	input  wire cfb_pkg::cfb_ge_t   ge_upd,       // Greater-equal flag update
	input  wire cfb_pkg::cfb_sreg_t sreg,         // Special register move
	input  wire cfb_pkg::cfb_mem_t  mreq,         // Direct or alias memory access
	input  wire logic [7:0]         irq_pending,  // Pending interrupts, 0 most urgent
	input  wire logic               use_psp,      // Thread code runs on process stack
	input  wire logic               frame_align8, // Frame alignment bit
	input  wire cfb_pkg::cfb_ctx_t  ctx,          // Registers to be stacked
	input  wire cfb_pkg::cfb_ret_t  ret,          // Pc load by pop, load or branch
	input  wire cfb_pkg::cfb_bus_t  rd_resp,      // Read data from memory system
	output cfb_pkg::cfb_bus_t       wr_req,       // Stack write to memory system
	output cfb_pkg::cfb_bus_t       rd_req,       // Vector or unstack read
	output logic [7:0]              irq_ack,      // Pulse: pending became active
	output logic [7:0]              irq_active,   // Active interrupts
	output logic [31:0]             sreg_rdata,   // Special register read data
	output logic                    sreg_rvalid,  // Special register read strobe
	output logic [31:0]             mem_rdata,    // Memory read data
	output logic                    mem_rvalid,   // Memory read strobe
	output cfb_pkg::cfb_status_t    status        // Architectural state
);
	cfb_pkg::cfb_st_t r;
	cfb_pkg::cfb_st_t n;
	logic [31:0]      mem [`CFB_MEM_WORDS];
	logic             mem_we;
	logic [4:0]       mem_widx;
	logic [31:0]      mem_wword;
	logic [31:0]      application_status_flags;

	// ************************************************************
	// Flag word
	// ************************************************************
	assign application_status_flags = {r.fn, r.fz, r.fc, r.fv, r.fq, 7'h00, r.ge, 16'h0000};

	assign wr_req      = r.wr;
	assign rd_req      = r.rd;
	assign irq_ack     = r.irq_ack;
	assign irq_active  = r.active;
	assign sreg_rdata  = r.sreg_rdata;
	assign sreg_rvalid = r.sreg_rvalid;
	assign mem_rdata   = r.mem_rdata;
	assign mem_rvalid  = r.mem_rvalid;
	assign status      = '{application_status_flags: application_status_flags, floor: r.floor, sp: r.sp, pc: r.pc, lr: r.lr,
	                       handler: r.handler, exc_num: r.exc_num};

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [32:0] sum;
		logic [31:0] res;
		logic [31:0] cur;
		logic [31:0] wmask;
		logic [4:0]  sh;
		logic [4:0]  widx;
		logic [2:0]  best;
		logic        best_ok;
		logic [31:0] frame_word;
		logic [31:0] base;
		logic        done;
		sum        = '0;
		res        = '0;
		cur        = '0;
		wmask      = '0;
		sh         = '0;
		widx       = '0;
		best       = '0;
		best_ok    = 1'b0;
		frame_word = '0;
		base       = '0;
		done       = 1'b0;
		n          = r; // No-operation slots fall through here untouched
		n.wr       = '0;
		n.rd.valid = 1'b0;
		n.irq_ack  = '0;
		n.sreg_rvalid = 1'b0;
		n.mem_rvalid  = 1'b0;
		mem_we     = 1'b0;
		mem_widx   = '0;
		mem_wword  = '0;

		// Special register moves
		if (sreg.valid && sreg.write) begin
			case (sreg.sel)
				`CFB_SEL_APPLICATION_STATUS_FLAGS, `CFB_SEL_PSR: begin
					// Only flag bits are writable; execution bits stay put
					if (sreg.sel == `CFB_SEL_APPLICATION_STATUS_FLAGS || sreg.priv) begin
						n.fn = sreg.data[`CFB_N_BIT];
						n.fz = sreg.data[`CFB_Z_BIT];
						n.fc = sreg.data[`CFB_C_BIT];
						n.fv = sreg.data[`CFB_V_BIT];
						n.fq = sreg.data[`CFB_Q_BIT];
						n.ge = sreg.data[`CFB_GE_HI:`CFB_GE_LO];
					end
				end
				`CFB_SEL_FLOOR: begin
					if (sreg.priv) begin
						n.floor = sreg.data[7:0];
					end
				end
				default: begin
					if (sreg.priv && sreg.data[7:0] != 8'h00 &&
					    (r.floor == 8'h00 || sreg.data[7:0] < r.floor)) begin
						n.floor = sreg.data[7:0];
					end
				end
			endcase
		end
		if (sreg.valid && !sreg.write) begin
			n.sreg_rvalid = 1'b1;
			case (sreg.sel)
				`CFB_SEL_APPLICATION_STATUS_FLAGS: n.sreg_rdata = application_status_flags;
				`CFB_SEL_PSR: n.sreg_rdata = sreg.priv ? (application_status_flags | {26'h0, r.exc_num}) : '0;
				default: n.sreg_rdata = sreg.priv ? {24'h0, r.floor} : '0;
			endcase
		end

		// Arithmetic flags
		if (alu.valid) begin
			if (alu.sub) begin
				sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 33'h1;
			end else begin
				sum = {1'b0, alu.a} + {1'b0, alu.b};
			end
			res  = sum[31:0];
			n.fn = res[31];
			n.fz = (res == 32'h00000000);
			n.fc = sum[32];
			if (alu.sub) begin
				n.fv = (alu.a[31] != alu.b[31]) && (res[31] != alu.a[31]);
			end else begin
				n.fv = (alu.a[31] == alu.b[31]) && (res[31] != alu.a[31]);
			end
		end
		if (ge_upd.valid) begin
			n.ge = ge_upd.ge;
		end
		// Set beats a same-cycle software clear
		if (sat.valid && sat.hit) begin
			n.fq = 1'b1;
		end

		// Alias and direct memory
		if (mreq.valid) begin
			if (mreq.alias_acc) begin
				widx = mreq.addr[11:7];
				cur  = mem[widx];
				if (mreq.write) begin
					mem_we    = 1'b1;
					mem_widx  = widx;
					mem_wword = cur;
					mem_wword[mreq.addr[6:2]] = mreq.wdata[0];
				end else begin
					n.mem_rvalid = 1'b1;
					n.mem_rdata  = {31'h0, cur[mreq.addr[6:2]]};
				end
			end else begin
				widx = mreq.addr[6:2];
				cur  = mem[widx];
				// Lane chosen by low address bits, lowest byte first
				case (mreq.size)
					`CFB_SIZE_BYTE: sh = {mreq.addr[1:0], 3'h0};
					`CFB_SIZE_HALF: sh = {mreq.addr[1], 4'h0};
					default: sh = 5'h00;
				endcase
				case (mreq.size)
					`CFB_SIZE_BYTE: wmask = 32'h000000ff << sh;
					`CFB_SIZE_HALF: wmask = 32'h0000ffff << sh;
					default: wmask = 32'hffffffff;
				endcase
				if (mreq.write) begin
					mem_we    = 1'b1;
					mem_widx  = widx;
					mem_wword = (cur & ~wmask) | ((mreq.wdata << sh) & wmask);
				end else begin
					n.mem_rvalid = 1'b1;
					n.mem_rdata  = (cur & wmask) >> sh;
				end
			end
		end

		// Most urgent interrupt allowed by the priority floor (priority = index + 1)
		for (int i = 7; i >= 0; i--) begin
			if (irq_pending[i] && !r.active[i] &&
			    (r.floor == 8'h00 || 8'(i + 1) < r.floor)) begin
				best    = 3'(i);
				best_ok = 1'b1;
			end
		end

		case (r.tgt)
			3'h0: frame_word = ctx.r0;
			default: frame_word = ctx.r0;
		endcase
		case (r.cnt)
			4'h0: frame_word = ctx.r0;
			4'h1: frame_word = ctx.r1;
			4'h2: frame_word = ctx.r2;
			4'h3: frame_word = ctx.r3;
			4'h4: frame_word = ctx.r12;
			4'h5: frame_word = ctx.lr;
			4'h6: frame_word = ctx.ret_pc;
			default: frame_word = application_status_flags | {26'h0, r.exc_num};
		endcase

		// ************************************************************
		// Exception sequencing
		// ************************************************************
		case (r.fsm)
			cfb_pkg::ST_IDLE: begin
				// Every pc-loading kind qualifies
				if (ret.valid && r.handler && ret.value[31:28] == 4'hf) begin
					n.fsm      = cfb_pkg::ST_UNSTACK;
					n.cnt      = 4'h0;
					n.rd.valid = 1'b1;
					n.rd.addr  = r.sp + `CFB_PC_SLOT_OFS;
				end else if (!r.handler && best_ok) begin
					base = r.sp - `CFB_FRAME_BYTES;
					base = frame_align8 ? (base & 32'hfffffff8) : (base & 32'hfffffffc);
					n.sp       = base;
					n.tgt      = best;
					n.cnt      = 4'h0;
					n.vec_done = 1'b0;
					n.refetch  = 1'b0;
					n.vec_wait = 1'b1;
					n.rd.valid = 1'b1;
					n.rd.addr  = `CFB_VEC_BASE +
					             {24'h0, (`CFB_IRQ_VEC_NUM + {3'h0, best}), 2'h0};
					n.fsm      = cfb_pkg::ST_STACK;
				end
			end
			cfb_pkg::ST_STACK: begin
				if (r.cnt != `CFB_FRAME_WORDS) begin
					n.wr.valid = 1'b1;
					n.wr.addr  = r.sp + {26'h0, r.cnt, 2'h0};
					n.wr.data  = frame_word;
					n.cnt      = r.cnt + 4'h1;
				end
				done = (r.cnt == `CFB_FRAME_WORDS) && r.vec_done;
				if (done) begin
					n.pc       = r.vec_pc;
					n.lr       = use_psp ? `CFB_RET_PSP : `CFB_RET_MSP;
					n.handler  = 1'b1;
					n.exc_num  = `CFB_IRQ_VEC_NUM + {3'h0, r.tgt};
					n.active[r.tgt]  = 1'b1;
					n.irq_ack[r.tgt] = 1'b1;
					n.fsm      = cfb_pkg::ST_IDLE;
				end else begin
					if (rd_resp.valid && r.vec_wait) begin
						n.vec_wait = 1'b0;
						if (r.refetch) begin
							n.refetch  = 1'b0;
							n.vec_wait = 1'b1;
							n.rd.valid = 1'b1;
							n.rd.addr  = `CFB_VEC_BASE +
							             {24'h0, (`CFB_IRQ_VEC_NUM + {3'h0, r.tgt}), 2'h0};
						end else begin
							n.vec_pc   = rd_resp.data;
							n.vec_done = 1'b1;
						end
					end
					// Late arrival: earlier one is simply left pending
					if (best_ok && best < r.tgt) begin
						n.tgt      = best;
						n.vec_done = 1'b0;
						if (n.vec_wait) begin
							n.refetch = 1'b1;
						end else begin
							n.vec_wait = 1'b1;
							n.rd.valid = 1'b1;
							n.rd.addr  = `CFB_VEC_BASE +
							             {24'h0, (`CFB_IRQ_VEC_NUM + {3'h0, best}), 2'h0};
						end
					end
				end
			end
			cfb_pkg::ST_UNSTACK: begin
				if (rd_resp.valid) begin
					if (r.cnt == 4'h0) begin
						n.pc       = rd_resp.data;
						n.cnt      = 4'h1;
						n.rd.valid = 1'b1;
						n.rd.addr  = r.sp + `CFB_PSR_SLOT_OFS;
					end else begin
						n.fn      = rd_resp.data[`CFB_N_BIT];
						n.fz      = rd_resp.data[`CFB_Z_BIT];
						n.fc      = rd_resp.data[`CFB_C_BIT];
						n.fv      = rd_resp.data[`CFB_V_BIT];
						n.fq      = rd_resp.data[`CFB_Q_BIT];
						n.ge      = rd_resp.data[`CFB_GE_HI:`CFB_GE_LO];
						n.sp      = r.sp + `CFB_FRAME_BYTES;
						n.handler = 1'b0;
						n.active[r.tgt] = 1'b0;
						n.exc_num = 6'h00;
						n.fsm     = cfb_pkg::ST_IDLE;
					end
				end
			end
			default: n.fsm = cfb_pkg::ST_IDLE;
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r       <= '0;
			r.fsm   <= cfb_pkg::ST_IDLE;
			{r.fn, r.fz, r.fc, r.fv, r.fq} <= 5'(`CFB_FLAGS_RESET >> `CFB_Q_BIT);
			r.ge    <= 4'h0;
			r.floor <= `CFB_FLOOR_RESET;
			r.sp    <= `CFB_SP_RESET;
		end else begin
			r <= n;
		end
	end

	// Memory is not reset; contents are undefined until written
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[mem_widx] <= mem_wword;
		end
	end
endmodule

// File: cfb_chk.sv
// Concurrent checks on the core flags block ports
`timescale 1ns/1ps
`include "cfb_defines.svh"
module cfb_chk (
	input wire logic               clock,       // Clock
	input wire logic               rst,         // Reset
	input wire cfb_pkg::cfb_alu_t  alu,         // Alu op
	input wire cfb_pkg::cfb_sat_t  sat,         // Saturate op
	input wire cfb_pkg::cfb_ge_t   ge_upd,      // Ge update
	input wire cfb_pkg::cfb_sreg_t sreg,        // Special move
	input wire cfb_pkg::cfb_mem_t  mreq,        // Memory access
	input wire logic [7:0]         irq_pending, // Pending
	input wire logic               use_psp,     // Stack select
	input wire logic               frame_align8,// Alignment
	input wire cfb_pkg::cfb_ctx_t  ctx,         // Context
	input wire cfb_pkg::cfb_ret_t  ret,         // Pc load
	input wire cfb_pkg::cfb_bus_t  rd_resp,     // Read answer
	input wire cfb_pkg::cfb_bus_t  wr_req,      // Stack write
	input wire cfb_pkg::cfb_bus_t  rd_req,      // Read request
	input wire logic [7:0]         irq_ack,     // Ack pulse
	input wire logic [7:0]         irq_active,  // Active
	input wire logic [31:0]        sreg_rdata,  // Move data
	input wire logic               sreg_rvalid, // Move strobe
	input wire logic [31:0]        mem_rdata,   // Memory data
	input wire logic               mem_rvalid,  // Memory strobe
	input wire cfb_pkg::cfb_status_t status     // State
);
	logic [32:0] sum;
	logic [3:0]  nzcv;
	always_comb begin
		sum = alu.sub ? {1'h0, alu.a} + {1'h0, ~alu.b} + 33'h1 : {1'h0, alu.a} + {1'h0, alu.b};
		nzcv = {sum[31], sum[31:0] == 32'h0, sum[32],
			(alu.a[31] == (alu.b[31] ^ alu.sub)) && (sum[31] != alu.a[31])};
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_enter;
		$rose(status.handler);
	endsequence
	sequence s_ret_go;
		ret.valid && status.handler && ret.value[31:28] == 4'hf && !rd_req.valid;
	endsequence
	sequence s_pc_fetch;
		rd_req.valid && rd_req.addr == status.sp + 32'h18;
	endsequence
	property p_nz;
		alu.valid |=> status.application_status_flags[31:30] == $past(nzcv[3:2]);
	endproperty
	property p_cv;
		alu.valid |=> status.application_status_flags[29:28] == $past(nzcv[1:0]);
	endproperty
	property p_q_set;
		sat.valid && sat.hit |=> status.application_status_flags[27];
	endproperty
	property p_q_hold;
		status.application_status_flags[27] && !sreg.valid && !rd_resp.valid |=> status.application_status_flags[27];
	endproperty
	property p_alias_rd;
		mreq.valid && mreq.alias_acc && !mreq.write |=> mem_rvalid && mem_rdata[31:1] == 31'h0;
	endproperty
	property p_unpriv_rd;
		sreg.valid && !sreg.write && !sreg.priv && sreg.sel != `CFB_SEL_APPLICATION_STATUS_FLAGS
			|=> sreg_rvalid && sreg_rdata == 32'h0;
	endproperty
	property p_raise;
		sreg.valid && sreg.write && sreg.sel == `CFB_SEL_RAISE && (sreg.data[7:0] == 8'h0
			|| (status.floor != 8'h0 && sreg.data[7:0] >= status.floor)) |=> $stable(status.floor);
	endproperty
	property p_lr;
		s_enter |-> status.lr == ($past(use_psp) ? `CFB_RET_PSP : `CFB_RET_MSP);
	endproperty
	property p_ack;
		irq_ack != 8'h0 |-> status.handler && irq_ack == (8'h1 << (status.exc_num - 6'h10));
	endproperty
	property p_frame;
		wr_req.valid |-> wr_req.addr - status.sp < 32'h20;
	endproperty
	property p_ret;
		s_ret_go |=> s_pc_fetch;
	endproperty
	a_nz: assert property (p_nz) else $error("nz flags wrong");
	a_cv: assert property (p_cv) else $error("cv flags wrong");
	a_q_set: assert property (p_q_set) else $error("q not set");
	a_q_hold: assert property (p_q_hold) else $error("q dropped");
	a_alias_rd: assert property (p_alias_rd) else $error("alias read wrong");
	a_unpriv_rd: assert property (p_unpriv_rd) else $error("unpriv read leak");
	a_raise: assert property (p_raise) else $error("raise not refused");
	a_lr: assert property (p_lr) else $error("return code wrong");
	a_ack: assert property (p_ack) else $error("ack mismatch");
	a_frame: assert property (p_frame) else $error("write outside frame");
	a_ret: assert property (p_ret) else $error("no pc fetch");
endmodule
bind cfb_core_flags cfb_chk cfb_chk_inst (.clock(clock), .rst(rst), .alu(alu), .sat(sat),
	.ge_upd(ge_upd), .sreg(sreg), .mreq(mreq), .irq_pending(irq_pending), .use_psp(use_psp),
	.frame_align8(frame_align8), .ctx(ctx), .ret(ret), .rd_resp(rd_resp), .wr_req(wr_req),
	.rd_req(rd_req), .irq_ack(irq_ack), .irq_active(irq_active), .sreg_rdata(sreg_rdata),
	.sreg_rvalid(sreg_rvalid), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .status(status));

// File: cfb_mem_model.sv
// Memory system and vector table facing the core flags block
`timescale 1ns/1ps
module cfb_mem_model (
	input  wire logic              clock,  // Clock
	input  wire logic              rst,    // Reset
	input  wire logic [3:0]        lat,    // Read latency
	input  wire cfb_pkg::cfb_bus_t wr_req, // Stack writes
	input  wire cfb_pkg::cfb_bus_t rd_req, // Reads
	output cfb_pkg::cfb_bus_t      rd_resp // Answers
);
	logic [31:0] mem [0:1023];
	logic [31:0] now;
	logic [43:0] pend [$];
	// Queue answers every read once, a stale vector fetch too
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			now <= 32'h0;
			pend.delete();
			rd_resp <= '0;
		end else begin
			now <= now + 32'h1;
			if (wr_req.valid) begin
				mem[wr_req.addr[11:2]] <= wr_req.data;
			end
			if (rd_req.valid) begin
				pend.push_back({now + {28'h0, lat}, rd_req.addr[11:0]});
			end
			if (pend.size() > 0 && pend[0][43:12] <= now) begin
				rd_resp.valid <= 1'h1;
				rd_resp.data <= mem[pend[0][11:2]];
				pend.pop_front();
			end else begin
				rd_resp.valid <= 1'h0;
				rd_resp.data <= ~rd_resp.data; // Idle bus inverts its data every cycle
			end
		end
	end
endmodule

// File: tb_top.sv
// Self-checking testbench of the core flags block
`timescale 1ns/1ps
`include "cfb_defines.svh"
module tb_top;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic [7:0] irq_pending = 8'h0;
	logic use_psp = 1'h0;
	logic [3:0] lat = 4'h3;
	logic [31:0] rd;
	int fails = 0;
	int n_checks = 0;
	cfb_pkg::cfb_alu_t alu = '0;
	cfb_pkg::cfb_sat_t sat = '0;
	cfb_pkg::cfb_ge_t ge_upd = '0;
	cfb_pkg::cfb_sreg_t sreg = '0;
	cfb_pkg::cfb_mem_t mreq = '0;
	cfb_pkg::cfb_ret_t ret = '0;
	cfb_pkg::cfb_ctx_t ctx = '{32'h10, 32'h11, 32'h12, 32'h13, 32'h1c, 32'h1e, 32'habc};
	cfb_pkg::cfb_bus_t wr_req, rd_req, rd_resp;
	cfb_pkg::cfb_status_t status;
	logic [31:0] op_a [5] = '{32'h5, 32'hffffffff, 32'h7fffffff, 32'h0, 32'h80000000};
	logic [31:0] op_b [5] = '{32'h5, 32'h2, 32'h1, 32'h1, 32'h1};
	logic [4:0]  op_x [5] = '{5'h16, 5'h02, 5'h09, 5'h18, 5'h13}; // Sub, then nzcv
	logic [7:0]  rz_d [4] = '{8'h50, 8'h00, 8'h20, 8'h30};
	logic [7:0]  rz_e [4] = '{8'h40, 8'h40, 8'h20, 8'h20};
	always #4 clock = ~clock;
	cfb_core_flags cfb_core_flags_inst (.clock(clock), .rst(rst), .alu(alu), .sat(sat),
		.ge_upd(ge_upd), .sreg(sreg), .mreq(mreq), .irq_pending(irq_pending),
		.use_psp(use_psp), .frame_align8(1'h1), .ctx(ctx), .ret(ret), .rd_resp(rd_resp),
		.wr_req(wr_req), .rd_req(rd_req), .irq_ack(), .irq_active(), .sreg_rdata(),
		.sreg_rvalid(), .mem_rdata(), .mem_rvalid(), .status(status));
	cfb_mem_model cfb_mem_model_inst (.clock(clock), .rst(rst), .lat(lat),
		.wr_req(wr_req), .rd_req(rd_req), .rd_resp(rd_resp));
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic sr(input logic w, input logic p, input logic [1:0] s, input logic [31:0] d);
		sreg = '{1'h1, w, p, s, d};
		tick();
		sreg.valid = 1'h0;
		tick();
	endtask
	task automatic mm(input logic al, input logic w, input logic [1:0] sz,
		input logic [11:0] a, input logic [31:0] d);
		mreq = '{1'h1, al, w, sz, a, d};
		tick();
		rd = cfb_core_flags_inst.mem_rdata;
		mreq.valid = 1'h0;
		tick();
	endtask
	task automatic wait_hdl(input logic lvl);
		int n;
		n = 0;
		while (status.handler !== lvl && n < 200) begin
			tick();
			n++;
		end
		chk({31'h0, status.handler}, {31'h0, lvl});
	endtask
	task automatic pc_load(input logic [1:0] k, input logic [31:0] v);
		ret = '{1'h1, k, v};
		tick();
		ret.valid = 1'h0;
	endtask
	task automatic print_verdict();
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clock);
		#1;
		rst = 1'h0;
		chk(status.application_status_flags, `CFB_FLAGS_RESET);
		chk(status.sp, `CFB_SP_RESET);
		for (int i = 0; i < 5; i++) begin
			alu = '{1'h1, op_x[i][4], op_a[i], op_b[i]};
			tick();
			alu.valid = 1'h0;
			tick();
			chk({28'h0, status.application_status_flags[31:28]}, {28'h0, op_x[i][3:0]});
		end
		sat = '{1'h1, 1'h1, 1'h1};
		tick();
		sat.valid = 1'h0;
		repeat (4) tick();
		chk(status.application_status_flags, 32'h38000000);
		sr(1'h1, 1'h0, `CFB_SEL_APPLICATION_STATUS_FLAGS, 32'h0);
		chk(status.application_status_flags, 32'h0);
		ge_upd = '{1'h1, 4'ha};
		tick();
		ge_upd.valid = 1'h0;
		tick();
		chk(status.application_status_flags, 32'h000a0000);
		sr(1'h1, 1'h0, `CFB_SEL_PSR, 32'hffffffff);
		chk(status.application_status_flags, 32'h000a0000);
		sr(1'h1, 1'h1, `CFB_SEL_PSR, 32'hffffffff);
		chk(status.application_status_flags, 32'hf80f0000);
		sr(1'h0, 1'h1, `CFB_SEL_APPLICATION_STATUS_FLAGS, 32'h0);
		chk(cfb_core_flags_inst.sreg_rdata, 32'hf80f0000);
		sr(1'h1, 1'h1, `CFB_SEL_FLOOR, 32'h40);
		sr(1'h0, 1'h0, `CFB_SEL_FLOOR, 32'h0);
		chk(cfb_core_flags_inst.sreg_rdata, 32'h0);
		sr(1'h1, 1'h1, `CFB_SEL_APPLICATION_STATUS_FLAGS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			sr(1'h1, 1'h1, `CFB_SEL_RAISE, {24'h0, rz_d[i]});
			chk({24'h0, status.floor}, {24'h0, rz_e[i]});
		end
		sr(1'h1, 1'h1, `CFB_SEL_FLOOR, 32'h0);
		sr(1'h1, 1'h1, `CFB_SEL_RAISE, 32'h60);
		chk({24'h0, status.floor}, 32'h60);
		sr(1'h1, 1'h1, `CFB_SEL_FLOOR, 32'h0);
		mm(1'h0, 1'h1, 2'h2, 12'h000, 32'h44332211);
		mm(1'h0, 1'h0, `CFB_SIZE_BYTE, 12'h001, 32'h0);
		chk(rd, 32'h22);
		mm(1'h0, 1'h0, `CFB_SIZE_HALF, 12'h002, 32'h0);
		chk(rd, 32'h4433);
		mm(1'h1, 1'h1, 2'h2, 12'h004, 32'hff);
		mm(1'h1, 1'h1, 2'h2, 12'h000, 32'h0e);
		mm(1'h1, 1'h0, 2'h2, 12'h004, 32'h0);
		chk(rd, 32'h1);
		mm(1'h1, 1'h0, 2'h2, 12'h000, 32'h0);
		chk(rd, 32'h0);
		mm(1'h0, 1'h0, 2'h2, 12'h000, 32'h0);
		chk(rd, 32'h44332212);
		cfb_mem_model_inst.mem[17] = 32'h200;
		cfb_mem_model_inst.mem[19] = 32'h300;
		// Less urgent source first, the urgent one arrives during stacking
		irq_pending = 8'h08;
		tick();
		irq_pending = 8'h0a;
		wait_hdl(1'h1);
		chk(status.pc, 32'h200);
		chk({26'h0, status.exc_num}, 32'h11);
		chk({24'h0, cfb_core_flags_inst.irq_ack}, 32'h02);
		chk({24'h0, cfb_core_flags_inst.irq_active}, 32'h02);
		chk(status.lr, `CFB_RET_MSP);
		chk(status.sp, 32'h3e0);
		chk(cfb_mem_model_inst.mem[254], 32'habc);
		pc_load(2'h0, 32'h1234);
		repeat (4) tick();
		chk({31'h0, status.handler}, 32'h1);
		irq_pending = 8'h08;
		use_psp = 1'h1;
		lat = 4'hc;
		pc_load(2'h1, `CFB_RET_MSP);
		wait_hdl(1'h0);
		chk(status.pc, 32'habc);
		chk(status.sp, 32'h400);
		wait_hdl(1'h1);
		chk(status.pc, 32'h300);
		chk({26'h0, status.exc_num}, 32'h13);
		chk(status.lr, `CFB_RET_PSP);
		sr(1'h0, 1'h1, `CFB_SEL_PSR, 32'h0);
		chk(cfb_core_flags_inst.sreg_rdata, 32'h00000013);
		irq_pending = 8'h0;
		pc_load(2'h2, `CFB_RET_PSP);
		wait_hdl(1'h0);
		chk(status.pc, 32'habc);
		print_verdict();
	end
endmodule
